// ---- hw/sbt_pkg.sv ----
package sbt_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CNT_LOW = 8'h04;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h10;
  localparam logic [7:0] ADDR_IRQ_PRIORITY = 8'h14;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h18;
  localparam logic [7:0] ADDR_CMP_CFG = 8'h1c;
  localparam logic [7:0] ADDR_CMP_VALUE = 8'h20;
  localparam logic [7:0] ADDR_GLOBAL_IRQ = 8'h24;
  // ----------------------------------------
  // Register fields, codes and constants
  // ----------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SRC = 1;
  localparam int CTRL_ASYNC = 2;
  localparam int CTRL_OSC_EN = 3;
  localparam int CTRL_PRE_LO = 4;
  localparam int CTRL_CLK_FLAG = 6;
  localparam int CTRL_WIDE = 7;
  localparam int IRQ_OVF_BIT = 0;
  localparam int OSC_IDLE_EN = 7;
  localparam int OSC_LOWPWR = 2;
  localparam int CMP_B_LO = 4;
  localparam int CMP_B_ADC_EN = 8;
  localparam logic [1:0] SCS_SECONDARY = 2'h1;
  localparam logic [3:0] CMP_MODE_SPECIAL = 4'hb;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CNT_WRAP = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  typedef enum logic [1:0] {SBT_PRIMARY, SBT_SEC_RUN, SBT_SEC_IDLE} sbt_pwr_e;
endpackage : sbt_pkg

// ---- hw/sbt_timer.sv ----
// How it works
// R1: Writing clock select 01 switches system clock to the timer oscillator.
// R2: Sleep in secondary run with idle enable clear enters secondary idle.
// R3: Control bit 6 reads set while the timer oscillator drives the system clock.
// R4: On oscillator failure the status bit follows the real clock source.
// R5: Low-power config bit selects low-power oscillator drive; default is high power.
// R6: Counter pair counts 0000h to FFFFh and wraps to 0000h.
// R7: Each wrap sets the sticky overflow flag until software clears it.
// R8: Overflow request goes out only while overflow enable is set.
// R9: Compare unit in mode 1011 resets the counter on its trigger.
// R10: Unit B trigger also starts a conversion when the converter is enabled; the code gives no start in async counter mode.
// R11: Trigger reset is skipped in asynchronous counter mode.
// R12: Compare value pair acts as the counter period under trigger reset.
// R13: Counter write in the trigger cycle wins over the trigger reset.
// R14: Unit B trigger reset never sets the overflow flag.
// R15: Async mode needs a low input level at or after an update to count the next rise.
// R16: Software sets only the high-byte MSb for one-second preloads.
// R17: Software keeps async mode, overflow enable and oscillator running for clocks.
// R18: Late updates wait for the low byte to step, then write within half period.
// R19: Source clear counts each instruction cycle; set counts rising external edges.
// R20: Sync select picks sync or async counting only for external source.
// R21: Prescale field divides by 1, 2, 4 or 8.
// R22: Wide mode: low read latches high byte; low write loads high and clears prescaler.
// R23: Counter and prescaler advance only while run enable is set.
//
// Register access over APB and the placing of the registers were decided locally.
module sbt_timer
  import sbt_pkg::*;
#(
  parameter int PRESCALE_W = 3
)
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_EXT_CLK,
  input wire logic I_OSC_FAIL,
  input wire logic I_SLEEP,
  output logic O_OVF_IRQ,
  output logic O_ADC_START,
  output logic O_SYSCLK_SECONDARY,
  output logic O_OSC_LOW_POWER,
  output logic O_OSC_ENABLE,
  output sbt_pkg::sbt_pwr_e O_PWR_MODE
);
  import sbt_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] counter_control;
  logic [7:0] counter_low_byte;
  logic [7:0] counter_high_byte;
  logic [7:0] high_buffer;
  logic [7:0] peripheral_interrupt_flags_one;
  logic [7:0] peripheral_interrupt_enables_one;
  logic [7:0] peripheral_interrupt_priority_one;
  logic [7:0] global_interrupt_control;
  logic [7:0] oscillator_control_reg;
  logic [8:0] compare_cfg;
  logic [15:0] compare_value_pair;
  sbt_pwr_e pwr_state;
  logic [PRESCALE_W-1:0] prescale_cnt;
  logic [1:0] instr_div;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic async_armed;

  logic wr_en;
  logic rd_en;
  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic tick_src;
  logic pre_done;
  logic step;
  logic wrap;
  logic trig_a;
  logic trig_b;
  logic trig_reset;
  logic period_match;
  logic secondary_clk;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [PRESCALE_W-1:0] pre_limit;
  logic [PRESCALE_W-1:0] next_prescale;

  assign count = {counter_high_byte, counter_low_byte};
  assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_en = I_PSEL && I_PENABLE && !I_PWRITE;
  assign wr_ctrl = wr_en && (I_PADDR == ADDR_CTRL);
  assign wr_low = wr_en && (I_PADDR == ADDR_CNT_LOW);
  assign wr_high = wr_en && (I_PADDR == ADDR_CNT_HIGH);
  assign rd_low = rd_en && (I_PADDR == ADDR_CNT_LOW);
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = 1'b0;

  // ----------------------------------------
  // External input synchroniser
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end
    else
    begin
      ext_meta <= I_EXT_CLK;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Async mode modelled on the sampled edge; a write re-arms only after a low level
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      async_armed <= 1'b1;
    else if (wr_low || wr_high)
      async_armed <= !ext_sync; // R15
    else if (!ext_sync)
      async_armed <= 1'b1; // R15
  end

  // ----------------------------------------
  // Clock source and prescaler
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      instr_div <= 2'h0;
    else
      instr_div <= instr_div + 2'h1;
  end

  always_comb
  begin
    if (!counter_control[CTRL_SRC])
      tick_src = (instr_div == INSTR_DIV_LAST); // R19 R20
    else if (counter_control[CTRL_ASYNC])
      tick_src = ext_sync && !ext_prev && async_armed; // R15 R19 R20
    else
      tick_src = ext_sync && !ext_prev; // R19
  end

  assign pre_limit = PRESCALE_W'((1 << counter_control[CTRL_PRE_LO +: 2]) - 1); // R21
  assign pre_done = (prescale_cnt == pre_limit);
  assign step = counter_control[CTRL_RUN] && tick_src && pre_done; // R23

  always_comb
  begin
    next_prescale = prescale_cnt;
    if (wr_low)
      next_prescale = '0; // R22
    else if (counter_control[CTRL_RUN] && tick_src) // R23
      next_prescale = pre_done ? '0 : prescale_cnt + PRESCALE_W'(1); // R21
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      prescale_cnt <= '0;
    else
      prescale_cnt <= next_prescale;
  end

  // ----------------------------------------
  // Special event trigger
  // ----------------------------------------
  assign period_match = (count == compare_value_pair) && step; // R12
  assign trig_a = period_match && (compare_cfg[3:0] == CMP_MODE_SPECIAL); // R9
  assign trig_b = period_match && (compare_cfg[CMP_B_LO +: 4] == CMP_MODE_SPECIAL); // R9
  // Async counting cannot be reset reliably, so trigger is dropped there
  assign trig_reset = (trig_a || trig_b) &&
                      !(counter_control[CTRL_SRC] && counter_control[CTRL_ASYNC]); // R11
  assign wrap = step && (count == CNT_WRAP) && !trig_reset; // R6 R14

  always_comb
  begin
    next_count = count;
    if (wr_low && counter_control[CTRL_WIDE])
      next_count = {high_buffer, I_PWDATA[7:0]}; // R13 R22
    else if (wr_low)
      next_count = {counter_high_byte, I_PWDATA[7:0]}; // R13
    else if (wr_high && !counter_control[CTRL_WIDE])
      next_count = {I_PWDATA[7:0], counter_low_byte}; // R13
    else if (trig_reset)
      next_count = CNT_ZERO; // R9 R12
    else if (step)
      next_count = count + 16'h0001; // R6
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      counter_low_byte <= 8'h00;
      counter_high_byte <= 8'h00;
    end
    else
    begin
      counter_low_byte <= next_count[7:0];
      counter_high_byte <= next_count[15:8];
    end
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      high_buffer <= 8'h00;
    else if (wr_high && counter_control[CTRL_WIDE])
      high_buffer <= I_PWDATA[7:0]; // R22
    else if (rd_low && counter_control[CTRL_WIDE])
      high_buffer <= counter_high_byte; // R22
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      O_ADC_START <= 1'b0;
    else
      O_ADC_START <= trig_b && !trig_reset ? 1'b0 : trig_b && compare_cfg[CMP_B_ADC_EN]; // R10
  end

  // ----------------------------------------
  // Interrupt flag, set wins over clear
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      peripheral_interrupt_flags_one <= 8'h00;
    else
    begin
      if (wr_en && I_PADDR == ADDR_IRQ_FLAGS)
        peripheral_interrupt_flags_one <= I_PWDATA[7:0];
      if (wrap)
        peripheral_interrupt_flags_one[IRQ_OVF_BIT] <= 1'b1; // R7
    end
  end

  assign O_OVF_IRQ = peripheral_interrupt_flags_one[IRQ_OVF_BIT] &&
                     peripheral_interrupt_enables_one[IRQ_OVF_BIT]; // R8

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      counter_control <= CTRL_RESET;
      peripheral_interrupt_enables_one <= 8'h00;
      peripheral_interrupt_priority_one <= 8'h00;
      global_interrupt_control <= 8'h00;
      oscillator_control_reg <= 8'h00;
      compare_cfg <= 9'h000;
      compare_value_pair <= CNT_WRAP;
    end
    else if (wr_en)
    begin
      case (I_PADDR)
        ADDR_CTRL: counter_control <= I_PWDATA[7:0];
        ADDR_IRQ_ENABLES: peripheral_interrupt_enables_one <= I_PWDATA[7:0];
        ADDR_IRQ_PRIORITY: peripheral_interrupt_priority_one <= I_PWDATA[7:0];
        ADDR_GLOBAL_IRQ: global_interrupt_control <= I_PWDATA[7:0];
        ADDR_OSC_CTRL: oscillator_control_reg <= I_PWDATA[7:0];
        ADDR_CMP_CFG: compare_cfg <= I_PWDATA[8:0];
        ADDR_CMP_VALUE: compare_value_pair <= I_PWDATA[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Clock source state
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      pwr_state <= SBT_PRIMARY;
    else
    begin
      case (pwr_state)
        SBT_PRIMARY:
          if (oscillator_control_reg[1:0] == SCS_SECONDARY && !I_OSC_FAIL)
            pwr_state <= SBT_SEC_RUN; // R1
        SBT_SEC_RUN:
          if (I_OSC_FAIL || oscillator_control_reg[1:0] != SCS_SECONDARY)
            pwr_state <= SBT_PRIMARY; // R4
          else if (I_SLEEP && !oscillator_control_reg[OSC_IDLE_EN])
            pwr_state <= SBT_SEC_IDLE; // R2
        SBT_SEC_IDLE:
          if (I_OSC_FAIL)
            pwr_state <= SBT_PRIMARY; // R4
          else if (!I_SLEEP)
            pwr_state <= SBT_SEC_RUN;
        default: pwr_state <= SBT_PRIMARY;
      endcase
    end
  end

  assign secondary_clk = (pwr_state != SBT_PRIMARY); // R3 R4
  assign O_SYSCLK_SECONDARY = secondary_clk; // R1
  assign O_PWR_MODE = pwr_state;
  assign O_OSC_LOW_POWER = oscillator_control_reg[OSC_LOWPWR]; // R5
  assign O_OSC_ENABLE = counter_control[CTRL_OSC_EN];

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      O_PRDATA <= 32'h0000_0000;
    else if (I_PSEL && !I_PENABLE && !I_PWRITE)
    begin
      case (I_PADDR)
        ADDR_CTRL: O_PRDATA <= {24'h0, counter_control[7], secondary_clk, counter_control[5:0]}; // R3
        ADDR_CNT_LOW: O_PRDATA <= {24'h0, counter_low_byte};
        ADDR_CNT_HIGH: O_PRDATA <= {24'h0, counter_control[CTRL_WIDE] ? high_buffer : counter_high_byte};
        ADDR_IRQ_FLAGS: O_PRDATA <= {24'h0, peripheral_interrupt_flags_one};
        ADDR_IRQ_ENABLES: O_PRDATA <= {24'h0, peripheral_interrupt_enables_one};
        ADDR_IRQ_PRIORITY: O_PRDATA <= {24'h0, peripheral_interrupt_priority_one};
        ADDR_GLOBAL_IRQ: O_PRDATA <= {24'h0, global_interrupt_control};
        ADDR_OSC_CTRL: O_PRDATA <= {24'h0, oscillator_control_reg};
        ADDR_CMP_CFG: O_PRDATA <= {23'h0, compare_cfg};
        ADDR_CMP_VALUE: O_PRDATA <= {16'h0, compare_value_pair};
        default: O_PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_wrap;
    wrap;
  endsequence

  AST_WRAP_SETS_FLAG: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R7
    s_wrap |=> peripheral_interrupt_flags_one[IRQ_OVF_BIT])
    else $error("overflow flag not set after wrap");
  AST_WRAP_ZERO: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R6
    s_wrap and (!wr_low && !wr_high) |=> count == CNT_ZERO)
    else $error("counter did not wrap to zero");
  AST_IRQ_GATE: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R8
    O_OVF_IRQ |-> peripheral_interrupt_enables_one[IRQ_OVF_BIT])
    else $error("irq without enable");
  AST_TRIG_ZERO: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R9
    trig_reset && !wr_en |=> count == CNT_ZERO)
    else $error("trigger did not clear counter");
  AST_WRITE_WINS: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R13
    trig_reset && wr_low && !counter_control[CTRL_WIDE] |=> counter_low_byte == $past(I_PWDATA[7:0]))
    else $error("trigger beat write");
  AST_STOPPED: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R23
    !counter_control[CTRL_RUN] && !wr_en |=> $stable(count))
    else $error("counter moved while stopped");
  AST_NO_ASYNC_TRIG: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R11
    counter_control[CTRL_SRC] && counter_control[CTRL_ASYNC] |-> !trig_reset)
    else $error("trigger reset in async mode");
  AST_SEC_STATUS: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R1
    pwr_state == SBT_PRIMARY && oscillator_control_reg[1:0] == SCS_SECONDARY && !I_OSC_FAIL
    |=> O_SYSCLK_SECONDARY)
    else $error("secondary switch missing");
  AST_FAIL_DROP: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R4
    I_OSC_FAIL |=> !O_SYSCLK_SECONDARY)
    else $error("status kept after oscillator failure");
  AST_IDLE_ENTRY: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // R2
    pwr_state == SBT_SEC_RUN && I_SLEEP && !I_OSC_FAIL && !oscillator_control_reg[OSC_IDLE_EN]
    && oscillator_control_reg[1:0] == SCS_SECONDARY |=> pwr_state == SBT_SEC_IDLE)
    else $error("secondary idle not entered");
endmodule : sbt_timer

// ---- bench/sbt_osc_model.sv ----
// ------
// Crystal model, idle low while disabled
// ------
module sbt_osc_model #(
  parameter int HALF_NS = 40
)
(
  input wire logic i_run,
  output logic o_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_clk = 1'b0;
  always
  begin
    #(HALF_NS);
    o_clk = i_run ? ~o_clk : 1'b0;
  end
endmodule : sbt_osc_model

// ---- bench/tb_top.sv ----
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  import sbt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sleep = 0, fail = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdv, prdata, lfsr = 32'h766c;
  logic pready, pslverr, ext_clk, irq, adc, sec, lowp, osc_en;
  logic [32:0] q[$], e;
  logic [11:0] cfgs[4] = '{12'h00b, 12'h1b0, 12'h00b, 12'h00b};
  logic [3:0] ctls[4] = '{4'h1, 4'h1, 4'hb, 4'hf};
  sbt_pwr_e mode;
  int mismatches = 0, checked = 0, cycles = 0, adc_n = 0, a0;
  always #4 clk = ~clk;
  sbt_timer sbt_timer_inst (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_EXT_CLK(ext_clk), .I_OSC_FAIL(fail), .I_SLEEP(sleep),
    .O_OVF_IRQ(irq), .O_ADC_START(adc), .O_SYSCLK_SECONDARY(sec), .O_OSC_LOW_POWER(lowp),
    .O_OSC_ENABLE(osc_en), .O_PWR_MODE(mode));
  sbt_osc_model sbt_osc_model_inst (.i_run(osc_en), .o_clk(ext_clk));
  // ------
  // Read watcher and run guard
  // ------
  always @(posedge clk)
  begin
    cycles++;
    if (adc === 1'b1)
      adc_n++;
    if (psel && pen && pready === 1'b1 && !pwr && q.size() > 0)
    begin
      e = q.pop_front();
      if (e[32])
        `CHK(prdata, e[31:0])
    end
    if (cycles == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // ------
  // APB master: request held until pready
  // ------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdv = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic c);
    q.push_back({c, x});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask : settle
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, 32'h0, 1'b1);
    rd(ADDR_CMP_VALUE, 32'hffff, 1'b1);
    wr(8'h28, 32'hff);
    rd(8'h28, 32'h0, 1'b1);
    // Random values through plain read/write registers
    for (int i = 0; i < 6; i++)
    begin
      lfsr = nxt(lfsr);
      wr(ADDR_IRQ_PRIORITY, lfsr);
      rd(ADDR_IRQ_PRIORITY, {24'h0, lfsr[7:0]}, 1'b1);
      wr(ADDR_GLOBAL_IRQ, lfsr >> 8);
      rd(ADDR_GLOBAL_IRQ, {24'h0, lfsr[15:8]}, 1'b1);
    end
    // Clock source switching and power modes
    wr(ADDR_CTRL, 32'h48);
    rd(ADDR_CTRL, 32'h08, 1'b1);
    wr(ADDR_OSC_CTRL, 32'h01);
    settle();
    `CHK(sec, 1'b1)
    `CHK(mode, SBT_SEC_RUN)
    rd(ADDR_CTRL, 32'h48, 1'b1);
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    settle();
    `CHK(mode, SBT_SEC_IDLE)
    @(posedge clk);
    sleep <= 1'b0;
    wr(ADDR_OSC_CTRL, 32'h81);
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    settle();
    `CHK(mode, SBT_SEC_RUN)
    @(posedge clk);
    sleep <= 1'b0;
    fail <= 1'b1;
    repeat (2) @(posedge clk);
    settle();
    `CHK(sec, 1'b0)
    wr(ADDR_OSC_CTRL, 32'h04);
    rd(ADDR_CTRL, 32'h08, 1'b1);
    fail <= 1'b0;
    settle();
    `CHK(lowp, 1'b1)
    wr(ADDR_OSC_CTRL, 32'h0);
    // Wrap, sticky flag and enable gating
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CNT_HIGH, 32'hff);
    wr(ADDR_CNT_LOW, 32'hfd);
    wr(ADDR_CTRL, 32'h01);
    repeat (40) @(posedge clk);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_CNT_HIGH, 32'h0, 1'b1);
    rd(ADDR_IRQ_FLAGS, 32'h01, 1'b1);
    settle();
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_ENABLES, 32'h01);
    settle();
    `CHK(irq, 1'b1)
    rd(ADDR_IRQ_FLAGS, 32'h01, 1'b1);
    wr(ADDR_IRQ_FLAGS, 32'h0);
    settle();
    `CHK(irq, 1'b0)
    // Every prescale code; a stopped count stays put
    for (int p = 0; p < 4; p++)
    begin
      wr(ADDR_CNT_HIGH, 32'h0);
      wr(ADDR_CNT_LOW, 32'h0);
      wr(ADDR_CTRL, {p[1:0], 4'h1});
      repeat (62) @(posedge clk);
      wr(ADDR_CTRL, 32'h0);
      rd(ADDR_CNT_LOW, 32'h0, 1'b0);
      `CHK((rdv[7:0] + 8'd1 - (8'd16 >> p)) <= 8'd2, 1'b1)
      rd(ADDR_CNT_LOW, rdv, 1'b1);
    end
    // Wide access through the high byte buffer
    wr(ADDR_CTRL, 32'h80);
    wr(ADDR_CNT_HIGH, 32'h12);
    wr(ADDR_CNT_LOW, 32'h34);
    rd(ADDR_CNT_LOW, 32'h34, 1'b1);
    rd(ADDR_CNT_HIGH, 32'h12, 1'b1);
    wr(ADDR_CNT_HIGH, 32'h56);
    rd(ADDR_CNT_LOW, 32'h34, 1'b1);
    rd(ADDR_CNT_HIGH, 32'h12, 1'b1);
    // Special event trigger as period, per source and mode
    wr(ADDR_CMP_VALUE, 32'h10);
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_CNT_HIGH, 32'h0);
      wr(ADDR_CNT_LOW, 32'h0);
      wr(ADDR_IRQ_FLAGS, 32'h0);
      wr(ADDR_CMP_CFG, cfgs[k]);
      a0 = adc_n;
      wr(ADDR_CTRL, ctls[k]);
      repeat (300) @(posedge clk);
      wr(ADDR_CTRL, 32'h0);
      rd(ADDR_CNT_LOW, 32'h0, 1'b0);
      `CHK((rdv[7:0] > 8'h10), (k == 3))
      rd(ADDR_CNT_HIGH, 32'h0, 1'b1);
      rd(ADDR_IRQ_FLAGS, 32'h0, cfgs[k][8]);
      `CHK((adc_n > a0), cfgs[k][8])
    end
    // Unit B trigger at the top of the count: zero, no overflow flag
    wr(ADDR_CMP_VALUE, 32'hffff);
    wr(ADDR_CMP_CFG, 32'h1b0);
    wr(ADDR_IRQ_FLAGS, 32'h0);
    wr(ADDR_CNT_HIGH, 32'hff);
    wr(ADDR_CNT_LOW, 32'hf8);
    a0 = adc_n;
    wr(ADDR_CTRL, 32'h01);
    repeat (60) @(posedge clk);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_CNT_HIGH, 32'h0, 1'b1);
    rd(ADDR_IRQ_FLAGS, 32'h0, 1'b1);
    `CHK((adc_n > a0), 1'b1)
    // Clock-style use: async external count, only the high byte preloaded
    wr(ADDR_IRQ_FLAGS, 32'h0);
    wr(ADDR_CMP_CFG, 32'h0);
    wr(ADDR_IRQ_ENABLES, 32'h01);
    wr(ADDR_CTRL, 32'h0f);
    rd(ADDR_CNT_LOW, 32'h0, 1'b0);
    a0 = rdv[7:0];
    while (rdv[7:0] == a0[7:0])
      rd(ADDR_CNT_LOW, 32'h0, 1'b0);
    @(negedge ext_clk);
    wr(ADDR_CNT_HIGH, 32'hff);
    while (irq !== 1'b1)
      @(posedge clk);
    rd(ADDR_CNT_HIGH, 32'h0, 1'b1);
    rd(ADDR_IRQ_FLAGS, 32'h01, 1'b1);
    wr(ADDR_CTRL, 32'h0);
    // Reset again in mid-run
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CNT_LOW, 32'h0, 1'b1);
    rd(ADDR_IRQ_ENABLES, 32'h0, 1'b1);
    wrap_up();
  end
endmodule : tb_top
